// file: sync_neg_pkg.sv
// Constants and types shared by the synchronous transfer negotiation block.
// Assumes a single 10 MHz clock and a byte stream from the message logic.
package sync_neg_pkg;

    // ========================================================================
    // Message layout
    localparam logic [7:0] EXT_MSG_MARK = 8'h01;
    localparam logic [7:0] SYNC_MSG_LEN = 8'h03;
    localparam logic [7:0] SYNC_MSG_CODE = 8'h01;
    localparam logic [2:0] REPLY_LAST_IDX = 3'h4;

    // ========================================================================
    // Period factor limits and timing units
    localparam logic [7:0] FACTOR_DIFF_MIN = 8'h0A;
    localparam logic [7:0] FACTOR_SINGLE_MIN = 8'h0C;
    localparam logic [7:0] FACTOR_MAX = 8'h6A;
    localparam logic [9:0] FACTOR_UNIT_NS = 10'h004;
    localparam logic [9:0] PERIOD_STEP_NS = 10'h019;
    localparam logic [4:0] STEPS_DIFF_MIN = 5'h01;
    localparam logic [4:0] STEPS_SINGLE_MIN = 5'h02;
    localparam logic [5:0] OFFSET_MAX = 6'h3F;

    // ========================================================================
    // Reset values
    localparam logic [7:0] RST_FACTOR = 8'h00;
    localparam logic [5:0] RST_OFFSET = 6'h00;
    localparam logic [4:0] RST_STEPS = 5'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // ========================================================================
    // Parser states, Gray coded along the usual path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_LEN = 3'h1,
        ST_CODE = 3'h3,
        ST_PERIOD = 3'h2,
        ST_OFFSET = 3'h6,
        ST_REPLY = 3'h7,
        ST_SKIP = 3'h5
    } parse_state_t;

endpackage : sync_neg_pkg

// file: sync_ff2.sv
// Two-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; no bus coherence across bits.
module sync_ff2 #(
    parameter int WIDTH = 3
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : sync_ff2

// file: sync_transfer_negotiation.sv
// Target-side parser and responder for the synchronous rate negotiation
// message, and holder of the agreed period and offset for data phases.
// Assumes message-out bytes arrive from the message logic on this clock and
// the reply bytes are drained by the same logic with a valid/ready handshake.

// Behaviour
// - Negotiation message is five bytes: 01, 03, 01, period factor, offset.
// - Agreed period is least spacing between leading edges of REQ or ACK.
// - Periods 50 ns to 425 ns in 25 ns steps are supported always.
// - A 25 ns period is supported only in differential receiver mode.
// - Offset bounds REQ pulses outstanding before the matching ACK arrives.
// - An agreed offset of zero selects asynchronous transfer.
// - Offsets 0 through 63 are accepted; larger requests clamp to 63.
// - ATN dropped before a multi-byte message ends forces bus free.
// - Power-on, bus reset or target reset invalidate the agreement.
// - A new negotiation may replace the agreement at any time.
// - Differential mode: factor 0-10 answers 10, factor 11-12 answers 12.
// - Single-ended mode: factor 0-12 answers 12.
// - Factors 13-106 echo unchanged; period rounds up to 25 ns multiple.
// - Factors 107-255 answer 106 and fall back to asynchronous transfer.
// - Unsupported code in a 3-byte extended message gets reject; continue with nexus, else bus free.
// - A width negotiation message reverts any agreement to asynchronous.
module sync_transfer_negotiation (
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [7:0] MSG_BYTE_IN,
    input wire logic MSG_VALID_IN,
    input wire logic ATN_IN,
    input wire logic DIFF_MODE_IN,
    input wire logic BUS_RESET_IN,
    input wire logic TARGET_RESET_IN,
    input wire logic WIDTH_MSG_IN,
    input wire logic NEXUS_VALID_IN,
    input wire logic LUN_IDENTIFIED_IN,
    input wire logic REPLY_READY_IN,
    output logic [7:0] REPLY_BYTE_OUT,
    output logic REPLY_VALID_OUT,
    output logic REJECT_OUT,
    output logic BUS_FREE_OUT,
    output logic SYNC_ACTIVE_OUT,
    output logic [7:0] PERIOD_FACTOR_OUT,
    output logic [5:0] OFFSET_OUT,
    output logic [4:0] PERIOD_STEPS_OUT,
    output logic NEGOTIATE_NEEDED_OUT
);

    // ========================================================================
    // Pin synchronisation
    logic [2:0] pins_sync;
    logic atn;
    logic differential_receiver_mode;
    logic bus_reset;

    sync_ff2 #(
        .WIDTH(3)
    ) u_pin_sync (
        .clk_in(REF_CLK_IN),
        .rst_n_in(RST_N_IN),
        .async_in({ATN_IN, DIFF_MODE_IN, BUS_RESET_IN}),
        .sync_out(pins_sync)
    );

    assign atn = pins_sync[2];
    assign differential_receiver_mode = pins_sync[1];
    assign bus_reset = pins_sync[0];

    // ========================================================================
    // Helper functions
    function automatic logic [7:0] grant_factor(input logic [7:0] f,
                                                input logic diff);
        if (f > sync_neg_pkg::FACTOR_MAX) begin
            grant_factor = sync_neg_pkg::FACTOR_MAX;
        end else if (diff && f <= sync_neg_pkg::FACTOR_DIFF_MIN) begin
            grant_factor = sync_neg_pkg::FACTOR_DIFF_MIN;
        end else if (f <= sync_neg_pkg::FACTOR_SINGLE_MIN) begin
            grant_factor = sync_neg_pkg::FACTOR_SINGLE_MIN;
        end else begin
            grant_factor = f;
        end
    endfunction : grant_factor

    // Period in 25 ns steps: 1 up to factor 10, 2 up to 12, else rounded up from factor times 4 ns.
    function automatic logic [4:0] period_steps(input logic [7:0] f);
        logic [9:0] ns;
        ns = 10'(f) * sync_neg_pkg::FACTOR_UNIT_NS;
        if (f <= sync_neg_pkg::FACTOR_DIFF_MIN) begin
            period_steps = sync_neg_pkg::STEPS_DIFF_MIN;
        end else if (f <= sync_neg_pkg::FACTOR_SINGLE_MIN) begin
            period_steps = sync_neg_pkg::STEPS_SINGLE_MIN;
        end else begin
            period_steps = 5'((ns + sync_neg_pkg::PERIOD_STEP_NS - 10'h001)
                              / sync_neg_pkg::PERIOD_STEP_NS);
        end
    endfunction : period_steps

    function automatic logic [7:0] reply_byte(input logic [2:0] idx,
                                              input logic [7:0] f,
                                              input logic [5:0] x);
        case (idx)
            3'h0: reply_byte = sync_neg_pkg::EXT_MSG_MARK;
            3'h1: reply_byte = sync_neg_pkg::SYNC_MSG_LEN;
            3'h2: reply_byte = sync_neg_pkg::SYNC_MSG_CODE;
            3'h3: reply_byte = f;
            default: reply_byte = {2'h0, x};
        endcase
    endfunction : reply_byte

    // ========================================================================
    // Message parser and reply sequencer
    sync_neg_pkg::parse_state_t state;
    logic [7:0] req_factor;
    logic [7:0] pend_factor;
    logic [5:0] pend_offset;
    logic [2:0] reply_idx;
    logic [7:0] skip_count;
    logic reply_done;
    logic atn_lost;
    logic [7:0] next_factor;
    logic [5:0] next_offset;

    // ATN may legally fall during the last byte only.
    assign atn_lost = !atn && !MSG_VALID_IN &&
                      (state == sync_neg_pkg::ST_LEN ||
                       state == sync_neg_pkg::ST_CODE ||
                       state == sync_neg_pkg::ST_PERIOD ||
                       state == sync_neg_pkg::ST_SKIP);
    assign reply_done = state == sync_neg_pkg::ST_REPLY && REPLY_VALID_OUT &&
                        REPLY_READY_IN &&
                        reply_idx == sync_neg_pkg::REPLY_LAST_IDX;

    always_comb begin
        next_factor = grant_factor(req_factor, differential_receiver_mode);
        if (req_factor > sync_neg_pkg::FACTOR_MAX) begin
            next_offset = 6'h00;
        end else if (MSG_BYTE_IN > {2'h0, sync_neg_pkg::OFFSET_MAX}) begin
            next_offset = sync_neg_pkg::OFFSET_MAX;
        end else begin
            next_offset = MSG_BYTE_IN[5:0];
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state <= sync_neg_pkg::ST_IDLE;
            req_factor <= sync_neg_pkg::RST_FACTOR;
            pend_factor <= sync_neg_pkg::RST_FACTOR;
            pend_offset <= sync_neg_pkg::RST_OFFSET;
            reply_idx <= 3'h0;
            skip_count <= 8'h00;
            REPLY_BYTE_OUT <= sync_neg_pkg::RST_BYTE;
            REPLY_VALID_OUT <= 1'b0;
            REJECT_OUT <= 1'b0;
            BUS_FREE_OUT <= 1'b0;
        end else begin
            REJECT_OUT <= 1'b0;
            BUS_FREE_OUT <= 1'b0;
            if (bus_reset || TARGET_RESET_IN) begin
                state <= sync_neg_pkg::ST_IDLE;
                REPLY_VALID_OUT <= 1'b0;
            end else if (atn_lost) begin
                state <= sync_neg_pkg::ST_IDLE;
                BUS_FREE_OUT <= 1'b1;
            end else begin
                case (state)
                    sync_neg_pkg::ST_IDLE: begin
                        if (MSG_VALID_IN && LUN_IDENTIFIED_IN &&
                            MSG_BYTE_IN == sync_neg_pkg::EXT_MSG_MARK) begin
                            state <= sync_neg_pkg::ST_LEN;
                        end
                    end
                    sync_neg_pkg::ST_LEN: begin
                        if (MSG_VALID_IN) begin
                            if (MSG_BYTE_IN == sync_neg_pkg::SYNC_MSG_LEN) begin
                                state <= sync_neg_pkg::ST_CODE;
                            end else if (MSG_BYTE_IN == 8'h00) begin
                                state <= sync_neg_pkg::ST_IDLE;
                            end else begin
                                // Other extended messages belong elsewhere.
                                skip_count <= MSG_BYTE_IN;
                                state <= sync_neg_pkg::ST_SKIP;
                            end
                        end
                    end
                    sync_neg_pkg::ST_SKIP: begin
                        if (MSG_VALID_IN) begin
                            skip_count <= skip_count - 8'h01;
                            if (skip_count == 8'h01) begin
                                state <= sync_neg_pkg::ST_IDLE;
                            end
                        end
                    end
                    sync_neg_pkg::ST_CODE: begin
                        if (MSG_VALID_IN) begin
                            if (MSG_BYTE_IN == sync_neg_pkg::SYNC_MSG_CODE) begin
                                state <= sync_neg_pkg::ST_PERIOD;
                            end else begin
                                REJECT_OUT <= 1'b1;
                                BUS_FREE_OUT <= !NEXUS_VALID_IN;
                                state <= sync_neg_pkg::ST_IDLE;
                            end
                        end
                    end
                    sync_neg_pkg::ST_PERIOD: begin
                        if (MSG_VALID_IN) begin
                            req_factor <= MSG_BYTE_IN;
                            state <= sync_neg_pkg::ST_OFFSET;
                        end
                    end
                    sync_neg_pkg::ST_OFFSET: begin
                        if (MSG_VALID_IN) begin
                            pend_factor <= next_factor;
                            pend_offset <= next_offset;
                            reply_idx <= 3'h0;
                            REPLY_BYTE_OUT <= sync_neg_pkg::EXT_MSG_MARK;
                            REPLY_VALID_OUT <= 1'b1;
                            state <= sync_neg_pkg::ST_REPLY;
                        end
                    end
                    sync_neg_pkg::ST_REPLY: begin
                        if (REPLY_READY_IN) begin
                            if (reply_idx == sync_neg_pkg::REPLY_LAST_IDX) begin
                                REPLY_VALID_OUT <= 1'b0;
                                state <= sync_neg_pkg::ST_IDLE;
                            end else begin
                                reply_idx <= reply_idx + 3'h1;
                                REPLY_BYTE_OUT <= reply_byte(reply_idx + 3'h1,
                                    pend_factor, pend_offset);
                            end
                        end
                    end
                    default: begin
                        state <= sync_neg_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ========================================================================
    // Agreement held for the data phase
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            SYNC_ACTIVE_OUT <= 1'b0;
            PERIOD_FACTOR_OUT <= sync_neg_pkg::RST_FACTOR;
            OFFSET_OUT <= sync_neg_pkg::RST_OFFSET;
            PERIOD_STEPS_OUT <= sync_neg_pkg::RST_STEPS;
        end else if (bus_reset || TARGET_RESET_IN || WIDTH_MSG_IN) begin
            SYNC_ACTIVE_OUT <= 1'b0;
            OFFSET_OUT <= sync_neg_pkg::RST_OFFSET;
        end else if (reply_done) begin
            SYNC_ACTIVE_OUT <= pend_offset != 6'h00;
            PERIOD_FACTOR_OUT <= pend_factor;
            OFFSET_OUT <= pend_offset;
            PERIOD_STEPS_OUT <= period_steps(pend_factor);
        end
    end

    // ========================================================================
    // Renegotiation request; a reset in the completing cycle wins.
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            NEGOTIATE_NEEDED_OUT <= 1'b1;
        end else if (bus_reset || TARGET_RESET_IN) begin
            NEGOTIATE_NEEDED_OUT <= 1'b1;
        end else if (reply_done) begin
            NEGOTIATE_NEEDED_OUT <= 1'b0;
        end
    end

endmodule : sync_transfer_negotiation

// file: sync_transfer_negotiation_monitor.sv
// Concurrent checks on the ports of the rate negotiation block.
// Assumes one clock domain; attached to the block by the bind below.
module sync_transfer_negotiation_monitor (
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic BUS_RESET_IN,
    input wire logic TARGET_RESET_IN,
    input wire logic WIDTH_MSG_IN,
    input wire logic NEXUS_VALID_IN,
    input wire logic REPLY_READY_IN,
    input wire logic [7:0] REPLY_BYTE_OUT,
    input wire logic REPLY_VALID_OUT,
    input wire logic REJECT_OUT,
    input wire logic BUS_FREE_OUT,
    input wire logic SYNC_ACTIVE_OUT,
    input wire logic [7:0] PERIOD_FACTOR_OUT,
    input wire logic [5:0] OFFSET_OUT,
    input wire logic [4:0] PERIOD_STEPS_OUT,
    input wire logic NEGOTIATE_NEEDED_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================================================
    // Assertions
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    reply_holds_a: assert property (REPLY_VALID_OUT && !REPLY_READY_IN
        && !TARGET_RESET_IN |=> REPLY_VALID_OUT && $stable(REPLY_BYTE_OUT))
        else $error("reply byte dropped before taken");
    reply_marker_a: assert property ($rose(REPLY_VALID_OUT)
        |-> REPLY_BYTE_OUT == 8'h01) else $error("reply not opened by 01");
    sync_flag_a: assert property (
        SYNC_ACTIVE_OUT == (OFFSET_OUT != 6'h00))
        else $error("sync flag disagrees with offset");
    steps_match_a: assert property (PERIOD_FACTOR_OUT != 8'h00
        |-> int'(PERIOD_STEPS_OUT) == (PERIOD_FACTOR_OUT <= 8'h0A ? 1 :
        PERIOD_FACTOR_OUT <= 8'h0C ? 2 : (int'(PERIOD_FACTOR_OUT) * 4 + 24)
        / 25)) else $error("period steps wrong");
    factor_range_a: assert property (PERIOD_FACTOR_OUT != 8'h00
        |-> PERIOD_FACTOR_OUT inside {[8'h0A:8'h6A]})
        else $error("granted factor out of range");
    tgt_reset_a: assert property (TARGET_RESET_IN |=>
        OFFSET_OUT == 6'h00 && NEGOTIATE_NEEDED_OUT)
        else $error("target reset ignored");
    bus_reset_a: assert property (BUS_RESET_IN [*5] |-> OFFSET_OUT == 6'h00
        && NEGOTIATE_NEEDED_OUT) else $error("bus reset ignored");
    width_a: assert property (WIDTH_MSG_IN |=> !SYNC_ACTIVE_OUT)
        else $error("width message kept sync");
    agree_load_a: assert property ($changed(OFFSET_OUT) && OFFSET_OUT !=
        6'h00 |-> $past(REPLY_VALID_OUT && REPLY_READY_IN))
        else $error("offset changed outside completion");
    need_clear_a: assert property ($fell(NEGOTIATE_NEEDED_OUT)
        |-> $past(REPLY_VALID_OUT && REPLY_READY_IN))
        else $error("agreement marked valid without completion");
    reject_free_a: assert property (REJECT_OUT
        |-> BUS_FREE_OUT == !$past(NEXUS_VALID_IN))
        else $error("reject without matching bus free choice");
endmodule : sync_transfer_negotiation_monitor

bind sync_transfer_negotiation sync_transfer_negotiation_monitor
    i_sync_transfer_negotiation_monitor (.REF_CLK_IN(REF_CLK_IN),
    .RST_N_IN(RST_N_IN), .BUS_RESET_IN(BUS_RESET_IN),
    .TARGET_RESET_IN(TARGET_RESET_IN), .WIDTH_MSG_IN(WIDTH_MSG_IN),
    .NEXUS_VALID_IN(NEXUS_VALID_IN), .REPLY_READY_IN(REPLY_READY_IN),
    .REPLY_BYTE_OUT(REPLY_BYTE_OUT), .REPLY_VALID_OUT(REPLY_VALID_OUT),
    .REJECT_OUT(REJECT_OUT), .BUS_FREE_OUT(BUS_FREE_OUT),
    .SYNC_ACTIVE_OUT(SYNC_ACTIVE_OUT), .PERIOD_FACTOR_OUT(PERIOD_FACTOR_OUT),
    .OFFSET_OUT(OFFSET_OUT), .PERIOD_STEPS_OUT(PERIOD_STEPS_OUT),
    .NEGOTIATE_NEEDED_OUT(NEGOTIATE_NEEDED_OUT));

// file: sync_initiator_model.sv
// Initiator-side model that drains and records the reply message.
// Assumes the reply valid/ready handshake on the block's clock.
module sync_initiator_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic slow_in,
    input wire logic clr_in,
    input wire logic [7:0] reply_byte_in,
    input wire logic reply_valid_in,
    output logic reply_ready_out,
    output logic [2:0] count_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] rx [0:4];
    // ========================================================================
    // A slow initiator takes a byte only every other cycle.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) reply_ready_out <= 1'b0;
        else reply_ready_out <= !slow_in || !reply_ready_out;
    end
    // ========================================================================
    // Reply bytes are kept in order; the bench reads all five back and checks
    // the header, factor and offset against the values it expects.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) count_out <= 3'h0;
        else if (clr_in) count_out <= 3'h0;
        else if (reply_valid_in && reply_ready_out && count_out < 3'h5) begin
            rx[count_out] <= reply_byte_in;
            count_out <= count_out + 3'h1;
        end
    end
endmodule : sync_initiator_model

// file: sync_transfer_negotiation_tb_top.sv
// Self-checking bench for the rate negotiation block.
// Assumes the initiator model drains replies; 10 MHz clock.
module sync_transfer_negotiation_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0, mvalid = 1'b0, atn = 1'b1, diff = 1'b0;
    logic bus_rst = 1'b0, tgt_rst = 1'b0, width = 1'b0, nexus = 1'b1;
    logic lun = 1'b1, slow = 1'b0, clr = 1'b0, rvalid, ready, reject, bfree;
    logic sact, need, rj, bf;
    logic [7:0] mbyte = 8'h00, rbyte, pfac;
    logic [5:0] offs;
    logic [4:0] steps;
    logic [2:0] cnt;
    int failures = 0, checked = 0;
    always #50 clk = ~clk;
    sync_transfer_negotiation i_sync_transfer_negotiation (.REF_CLK_IN(clk),
        .RST_N_IN(rst_n), .MSG_BYTE_IN(mbyte), .MSG_VALID_IN(mvalid),
        .ATN_IN(atn), .DIFF_MODE_IN(diff), .BUS_RESET_IN(bus_rst),
        .TARGET_RESET_IN(tgt_rst), .WIDTH_MSG_IN(width),
        .NEXUS_VALID_IN(nexus), .LUN_IDENTIFIED_IN(lun),
        .REPLY_READY_IN(ready), .REPLY_BYTE_OUT(rbyte),
        .REPLY_VALID_OUT(rvalid), .REJECT_OUT(reject), .BUS_FREE_OUT(bfree),
        .SYNC_ACTIVE_OUT(sact), .PERIOD_FACTOR_OUT(pfac), .OFFSET_OUT(offs),
        .PERIOD_STEPS_OUT(steps), .NEGOTIATE_NEEDED_OUT(need));
    sync_initiator_model i_sync_initiator_model (.clk_in(clk),
        .rst_n_in(rst_n), .slow_in(slow), .clr_in(clr), .reply_byte_in(rbyte),
        .reply_valid_in(rvalid), .reply_ready_out(ready), .count_out(cnt));
    // ========================================================================
    // Shared tasks
    task automatic check(input logic ok, input string what);
        checked++;
        if (ok !== 1'b1) begin
            failures++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask : check
    task automatic send(input logic [7:0] b [0:4], input int n);
        @(posedge clk);
        clr <= 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            clr <= 1'b0;
            mbyte <= b[i];
            mvalid <= 1'b1;
        end
        @(posedge clk);
        mvalid <= 1'b0;
    endtask : send
    task automatic watch();
        rj = 1'b0;
        bf = 1'b0;
        repeat (8) begin
            @(posedge clk);
            rj |= reject;
            bf |= bfree;
        end
    endtask : watch
    task automatic negotiate(input logic d, input logic [7:0] m, x, emt,
            input logic [5:0] ex);
        int n;
        int es;
        logic [7:0] r [0:4];
        n = 0;
        es = emt <= 8'h0A ? 1 : emt <= 8'h0C ? 2 : (int'(emt) * 4 + 24) / 25;
        @(posedge clk);
        diff <= d;
        repeat (4) @(posedge clk);
        send('{8'h01, 8'h03, 8'h01, m, x}, 5);
        while (cnt !== 3'h5 && n < 200) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        #1;
        r = i_sync_initiator_model.rx;
        check(r[0] === 8'h01 && r[1] === 8'h03 && r[2] === 8'h01 &&
            r[3] === emt, "reply head");
        check(r[4] === {2'b00, ex}, "offset");
        check(cnt === 3'h5 && pfac === emt && offs === ex &&
            need === 1'b0, "agreed");
        check(sact === (ex != 6'h00), "mode");
        check(steps === 5'(es), "steps");
    endtask : negotiate
    // ========================================================================
    // Scenarios
    task automatic t_table();
        negotiate(1'b1, 8'h00, 8'h08, 8'h0A, 6'h08);
        negotiate(1'b1, 8'h0B, 8'h08, 8'h0C, 6'h08);
        negotiate(1'b0, 8'h00, 8'h0F, 8'h0C, 6'h0F);
        negotiate(1'b0, 8'h0C, 8'h0F, 8'h0C, 6'h0F);
        negotiate(1'b1, 8'h12, 8'h3F, 8'h12, 6'h3F);
        negotiate(1'b0, 8'h6A, 8'h40, 8'h6A, 6'h3F);
        negotiate(1'b1, 8'h6B, 8'h08, 8'h6A, 6'h00);
        negotiate(1'b0, 8'hFF, 8'h08, 8'h6A, 6'h00);
        negotiate(1'b0, 8'h32, 8'h00, 8'h32, 6'h00);
        slow <= 1'b1;
        negotiate(1'b0, 8'h0D, 8'h05, 8'h0D, 6'h05);
        slow <= 1'b0;
    endtask : t_table
    task automatic t_resets();
        negotiate(1'b0, 8'h14, 8'h09, 8'h14, 6'h09);
        @(posedge clk);
        tgt_rst <= 1'b1;
        @(posedge clk);
        tgt_rst <= 1'b0;
        @(posedge clk);
        #1;
        check(offs === 6'h00 && sact === 1'b0 && need === 1'b1, "tr");
        negotiate(1'b0, 8'h14, 8'h09, 8'h14, 6'h09);
        @(posedge clk);
        width <= 1'b1;
        @(posedge clk);
        width <= 1'b0;
        @(posedge clk);
        #1;
        check(offs === 6'h00 && sact === 1'b0 && need === 1'b0, "wd");
        negotiate(1'b1, 8'h14, 8'h09, 8'h14, 6'h09);
        @(posedge clk);
        bus_rst <= 1'b1;
        repeat (6) @(posedge clk);
        bus_rst <= 1'b0;
        #1;
        check(offs === 6'h00 && need === 1'b1, "bus reset");
    endtask : t_resets
    task automatic t_reject();
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            nexus <= k[0];
            send('{8'h01, 8'h03, 8'h02, 8'h00, 8'h00}, 3);
            watch();
            check(rj === 1'b1 && bf === !k[0] && cnt === 3'h0, "rej");
        end
        nexus <= 1'b1;
        // An extended message of another length is skipped without answer.
        send('{8'h01, 8'h02, 8'h03, 8'h01, 8'h00}, 4);
        watch();
        check(rj === 1'b0 && bf === 1'b0 && cnt === 3'h0, "skip");
    endtask : t_reject
    task automatic t_atn_lun();
        send('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00}, 2);
        atn <= 1'b0;
        watch();
        check(bf === 1'b1 && cnt === 3'h0, "atn loss");
        atn <= 1'b1;
        lun <= 1'b0;
        repeat (4) @(posedge clk);
        send('{8'h01, 8'h03, 8'h01, 8'h20, 8'h04}, 5);
        repeat (20) @(posedge clk);
        check(cnt === 3'h0 && rvalid === 1'b0, "unidentified");
        lun <= 1'b1;
    endtask : t_atn_lun
    // ========================================================================
    // Run control
    task automatic give_verdict();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    initial begin
        #2000000;
        failures++;
        give_verdict();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check(need === 1'b1 && offs === 6'h00 && sact === 1'b0, "po");
        t_table();
        t_resets();
        t_reject();
        t_atn_lun();
        give_verdict();
    end
endmodule : sync_transfer_negotiation_tb_top
